/* src/ampc_map.svh */
// Constants for the amplifier reset, mute and mode controller
// Summary of operation
// - While reset is held low, modulator stops and bridges float.
// - After reset release, a timed start-up initialises modulator and protection.
// - After start-up with mute low, modulator runs but bridges stay undriven.
// - Releasing mute starts driving outputs through a pop-free soft start.
// - Output transistors never switch while mute is held low.
// - Mono select sampled at reset release; high drives both bridges from left.
// - In mono mode only left feedback is used; right feedback ignored.
// - Modulator sampling rate is the input clock divided by two.
// - Each channel is a seventh-order one-bit modulator driving its bridge.
// - Above a modulation threshold, drop to second order, return below it.
// - Switching-rate reduction cuts average output transitions about fourfold.
`ifndef AMPC_MAP_SVH
`define AMPC_MAP_SVH

`define AMPC_CLK_MHZ 50
`define AMPC_INIT_TIME_US 100
`define AMPC_INIT_CYCLES (`AMPC_INIT_TIME_US * `AMPC_CLK_MHZ)
`define AMPC_SOFT_STEP_US 50
`define AMPC_SOFT_STEP_CYCLES (`AMPC_SOFT_STEP_US * `AMPC_CLK_MHZ)
`define AMPC_SOFT_STEPS 8
`define AMPC_CNT_W 16
`define AMPC_SMP_W 16
`define AMPC_ACC_W 24
`define AMPC_HI_ORDER 7
`define AMPC_LO_ORDER 2
`define AMPC_RATE_HOLD 4
`define AMPC_ORDER_THRESH 29491

`endif

/* src/ampc_pkg.sv */
// Types shared by the amplifier controller and its modulator
package ampc_pkg;

  // Sequencer states, Gray coded along reset, init, muted, soft, play
  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_INIT = 3'b001,
    ST_MUTED = 3'b011,
    ST_SOFT = 3'b010,
    ST_PLAY = 3'b110
  } ampc_state_t;

  // Bridge feedback senses, one bit per bridge leg
  typedef struct packed {
    logic l_pos;
    logic l_neg;
    logic r_pos;
    logic r_neg;
  } ampc_fb_t;

  // Drive pair for one full bridge
  typedef struct packed {
    logic pos;
    logic neg;
  } ampc_bridge_t;

endpackage

/* src/ampc_sdm.sv */
// One channel sigma-delta modulator with order and rate reduction
`timescale 1ns/100ps
`default_nettype none
`include "ampc_map.svh"

module ampc_sdm
  import ampc_pkg::*;
#(
  parameter int SMP_W = `AMPC_SMP_W,
  parameter int ACC_W = `AMPC_ACC_W,
  parameter int ORDER = `AMPC_HI_ORDER
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic run,
  input wire logic tick,
  input wire logic signed [SMP_W-1:0] sample_in,
  input wire logic fb_bit,
  output logic q_out,
  output logic low_order
);

  localparam logic signed [ACC_W-1:0] FS = ACC_W'(1 << (SMP_W - 1));
  localparam logic signed [ACC_W-1:0] AMAX = {1'b0, {(ACC_W-1){1'b1}}};
  // Signed limit one bit wider, so negative sums compare as negative
  localparam logic signed [ACC_W:0] SMAX = {1'b0, AMAX};
  localparam logic [SMP_W-1:0] THRESH = SMP_W'(`AMPC_ORDER_THRESH);

  logic signed [ACC_W-1:0] acc_ff [ORDER];
  logic signed [ACC_W-1:0] nxt_acc [ORDER];
  logic q_ff, nxt_q;
  logic lo_ff, nxt_lo;
  logic [2:0] hold_ff, nxt_hold;

  // Saturating add keeps a clipped loop from wrapping round
  function automatic logic signed [ACC_W-1:0] sat_add(
    input logic signed [ACC_W-1:0] a,
    input logic signed [ACC_W-1:0] b);
    logic signed [ACC_W:0] s;
    s = {a[ACC_W-1], a} + {b[ACC_W-1], b};
    if (s > SMAX)
      return AMAX;
    else if (s < -SMAX)
      return -AMAX;
    else
      return s[ACC_W-1:0];
  endfunction

  function automatic logic [SMP_W-1:0] mag(
    input logic signed [SMP_W-1:0] v);
    return v[SMP_W-1] ? SMP_W'(-v) : v;
  endfunction

  // Integrator chain, quantizer and hold counter, stepped on each tick
  always_comb begin
    logic signed [ACC_W-1:0] err;
    logic dec;
    err = '0;
    dec = 1'b0;
    nxt_acc = acc_ff;
    nxt_q = q_ff;
    nxt_lo = lo_ff;
    nxt_hold = hold_ff;
    if (!run) begin
      for (int k = 0; k < ORDER; k++)
        nxt_acc[k] = '0;
      nxt_q = 1'b0;
      nxt_lo = 1'b0;
      nxt_hold = '0;
    end else if (tick) begin
      nxt_lo = mag(sample_in) > THRESH;
      err = ACC_W'(sample_in) - (fb_bit ? FS : -FS);
      nxt_acc[0] = sat_add(acc_ff[0], err);
      for (int k = 1; k < ORDER; k++) begin
        if (nxt_lo && k >= `AMPC_LO_ORDER)
          nxt_acc[k] = '0;  // Clear upper stages so return is clean
        else
          nxt_acc[k] = sat_add(acc_ff[k], acc_ff[k-1] >>> 2);
      end
      dec = nxt_lo ? ~acc_ff[`AMPC_LO_ORDER-1][ACC_W-1]
                   : ~acc_ff[ORDER-1][ACC_W-1];
      // output may only flip once per hold window
      if (hold_ff != 3'h0) begin
        nxt_hold = hold_ff - 3'h1;
      end else if (dec != q_ff) begin
        nxt_q = dec;
        nxt_hold = 3'(`AMPC_RATE_HOLD - 1);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      for (int k = 0; k < ORDER; k++)
        acc_ff[k] <= '0;
      q_ff <= 1'b0;
      lo_ff <= 1'b0;
      hold_ff <= 3'h0;
    end else begin
      acc_ff <= nxt_acc;
      q_ff <= nxt_q;
      lo_ff <= nxt_lo;
      hold_ff <= nxt_hold;
    end
  end

  assign q_out = q_ff;
  assign low_order = lo_ff;

  // Large input must select the low order on the very next edge
  a_order_drop: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    run && tick && (mag(sample_in) > THRESH) |=> low_order)
    else $error("order not reduced above threshold");

endmodule
`default_nettype wire

/* src/ampc_ctrl.sv */
// Reset, mute and mono sequencing with two-channel bridge drive
`timescale 1ns/100ps
`default_nettype none
`include "ampc_map.svh"

module ampc_ctrl
  import ampc_pkg::*;
#(
  parameter int INIT_CYCLES = `AMPC_INIT_CYCLES,
  parameter int SOFT_STEP_CYCLES = `AMPC_SOFT_STEP_CYCLES,
  parameter int SMP_W = `AMPC_SMP_W
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic mute_n,
  input wire logic mono_sel,
  input wire logic signed [SMP_W-1:0] audio_l,
  input wire logic signed [SMP_W-1:0] audio_r,
  input wire ampc_fb_t fb_in,
  output logic left_bridge_pos_out,
  output logic left_bridge_neg_out,
  output logic right_bridge_pos_out,
  output logic right_bridge_neg_out,
  output logic [1:0] bridge_oe_n,
  output logic modulator_running,
  output logic mono_active,
  output logic soft_active
);

  localparam logic [`AMPC_CNT_W-1:0] INIT_LAST = `AMPC_CNT_W'(INIT_CYCLES - 1);
  localparam logic [`AMPC_CNT_W-1:0] STEP_LAST =
    `AMPC_CNT_W'(SOFT_STEP_CYCLES - 1);
  localparam logic [3:0] STEPS = 4'(`AMPC_SOFT_STEPS);

  ampc_state_t st_ff, nxt_st;
  logic [`AMPC_CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [3:0] ramp_ff, nxt_ramp;
  logic mono_ff, nxt_mono;
  logic div_ff, nxt_div;
  ampc_bridge_t lb_ff, nxt_lb, rb_ff, nxt_rb;
  logic [1:0] oe_n_ff, nxt_oe_n;
  logic run_ff, nxt_run;
  logic soft_ff, nxt_soft;
  logic drive, l_run, r_run, tick;
  logic l_fb, r_fb, l_q, r_q;
  logic signed [SMP_W-1:0] l_smp, r_smp;

  // Scale a sample by the soft-start ramp; full level at the last step
  function automatic logic signed [SMP_W-1:0] ramp_scale(
    input logic signed [SMP_W-1:0] v,
    input logic [3:0] step);
    return v >>> (STEPS - step);
  endfunction

  // Sequencer: reset, start-up, muted, soft start, play
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_ramp = ramp_ff;
    nxt_mono = mono_ff;
    unique case (st_ff)
      ST_RESET: begin
        // mono level caught on first edge after release
        nxt_mono = mono_sel;
        nxt_cnt = '0;
        nxt_st = ST_INIT;
      end
      ST_INIT: begin
        if (cnt_ff == INIT_LAST) begin
          nxt_cnt = '0;
          nxt_st = ST_MUTED;
        end else begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
      ST_MUTED: begin
        nxt_ramp = '0;
        nxt_cnt = '0;
        if (mute_n)
          nxt_st = ST_SOFT;
      end
      ST_SOFT: begin
        if (!mute_n) begin
          nxt_st = ST_MUTED;
        end else if (cnt_ff == STEP_LAST) begin
          nxt_cnt = '0;
          nxt_ramp = ramp_ff + 4'h1;
          if (ramp_ff == STEPS - 4'h1)
            nxt_st = ST_PLAY;
        end else begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
      ST_PLAY: begin
        // renewed mute stops switching at once
        if (!mute_n)
          nxt_st = ST_MUTED;
      end
      default: nxt_st = ST_RESET;
    endcase
  end

  // reset holds the lowest power state
  // mono choice only reloads through reset
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st_ff <= ST_RESET;
      cnt_ff <= '0;
      ramp_ff <= 4'h0;
      mono_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      ramp_ff <= nxt_ramp;
      mono_ff <= nxt_mono;
    end
  end

  // sample tick at half the input clock
  assign nxt_div = ~div_ff;
  assign tick = div_ff;

  // Left modulator runs from the end of start-up onward; right one only when not mono
  assign nxt_run = (nxt_st == ST_MUTED) || (nxt_st == ST_SOFT) ||
                   (nxt_st == ST_PLAY);
  assign drive = (st_ff == ST_SOFT) || (st_ff == ST_PLAY);
  assign l_run = run_ff;
  assign r_run = run_ff && !mono_ff;

  // mono loop closes on left feedback only
  // Undriven bridges give no feedback, so the loop closes internally
  assign l_fb = drive ? (fb_in.l_pos & ~fb_in.l_neg) : l_q;
  assign r_fb = drive ? (fb_in.r_pos & ~fb_in.r_neg) : r_q;
  assign l_smp = ramp_scale(audio_l, ramp_ff);
  assign r_smp = ramp_scale(audio_r, ramp_ff);

  ampc_sdm #(
    .SMP_W(SMP_W),
    .ACC_W(`AMPC_ACC_W),
    .ORDER(`AMPC_HI_ORDER)
  ) u_sdm_l (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .run(l_run),
    .tick(tick),
    .sample_in(l_smp),
    .fb_bit(l_fb),
    .q_out(l_q),
    .low_order()
  );

  ampc_sdm #(
    .SMP_W(SMP_W),
    .ACC_W(`AMPC_ACC_W),
    .ORDER(`AMPC_HI_ORDER)
  ) u_sdm_r (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .run(r_run),
    .tick(tick),
    .sample_in(r_smp),
    .fb_bit(r_fb),
    .q_out(r_q),
    .low_order()
  );

  // Bridge drive: legs idle low and floating unless soft or play
  always_comb begin
    nxt_lb = '0;
    nxt_rb = '0;
    nxt_oe_n = 2'b11;
    nxt_soft = (nxt_st == ST_SOFT);
    // no switching while mute is low
    if ((nxt_st == ST_SOFT) || (nxt_st == ST_PLAY)) begin
      nxt_oe_n = 2'b00;
      // two-level stream drives the bridge differentially
      nxt_lb = '{pos: l_q, neg: ~l_q};
      // mono drives both bridges in parallel from left
      nxt_rb = mono_ff ? '{pos: l_q, neg: ~l_q} : '{pos: r_q, neg: ~r_q};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      div_ff <= 1'b0;
      run_ff <= 1'b0;
      lb_ff <= '0;
      rb_ff <= '0;
      oe_n_ff <= 2'b11;
      soft_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      run_ff <= nxt_run;
      lb_ff <= nxt_lb;
      rb_ff <= nxt_rb;
      oe_n_ff <= nxt_oe_n;
      soft_ff <= nxt_soft;
    end
  end

  assign left_bridge_pos_out = lb_ff.pos;
  assign left_bridge_neg_out = lb_ff.neg;
  assign right_bridge_pos_out = rb_ff.pos;
  assign right_bridge_neg_out = rb_ff.neg;
  assign bridge_oe_n = oe_n_ff;
  assign modulator_running = run_ff;
  assign mono_active = mono_ff;
  assign soft_active = soft_ff;

  // Checks on the sequencing and drive
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_reset_floats: assert property (
    (st_ff == ST_RESET) |-> (bridge_oe_n == 2'b11) && !modulator_running)
    else $error("bridges or modulator active during reset");
  a_init_follows: assert property (
    (st_ff == ST_RESET) |=> (st_ff == ST_INIT) ##1
    (st_ff == ST_INIT) && !modulator_running)
    else $error("start-up did not follow reset release");
  a_muted_running: assert property (
    (st_ff == ST_MUTED) && !mute_n |=> modulator_running &&
    (bridge_oe_n == 2'b11))
    else $error("muted state drove bridges or stopped modulator");
  a_unmute_soft: assert property (
    (st_ff == ST_MUTED) && mute_n |=> (st_ff == ST_SOFT) && soft_active &&
    (bridge_oe_n == 2'b00))
    else $error("unmute did not enter soft start");
  a_mute_silent: assert property (
    !mute_n && (st_ff != ST_RESET) |=> (bridge_oe_n == 2'b11) &&
    !left_bridge_pos_out && !right_bridge_pos_out &&
    !left_bridge_neg_out && !right_bridge_neg_out)
    else $error("bridge switching while muted");
  a_mono_parallel: assert property (
    mono_active && (bridge_oe_n == 2'b00) |->
    (right_bridge_pos_out == left_bridge_pos_out) &&
    (right_bridge_neg_out == left_bridge_neg_out))
    else $error("mono bridges differ");
  a_mono_right_off: assert property (
    mono_ff |-> !r_run && !r_q)
    else $error("right modulator running in mono");
  a_div_half: assert property (
    tick |=> !tick ##1 tick)
    else $error("sample tick not at half clock");
  a_mono_stable: assert property (
    (st_ff != ST_RESET) |=> $stable(mono_ff))
    else $error("mono choice changed without reset");
  a_diff_drive: assert property (
    (bridge_oe_n == 2'b00) |->
    (left_bridge_pos_out != left_bridge_neg_out))
    else $error("bridge legs not complementary");

  c_reach_play: cover property ((st_ff == ST_SOFT) ##1 (st_ff == ST_PLAY));
  c_remute: cover property ((st_ff == ST_PLAY) ##1 (st_ff == ST_MUTED));
  c_mono_drive: cover property (mono_active && (bridge_oe_n == 2'b00));
  c_soft_abort: cover property ((st_ff == ST_SOFT) ##1 (st_ff == ST_MUTED));

endmodule
`default_nettype wire

/* dv/ampc_host.sv */
// Host controller model driving reset, mute and mono select
`timescale 1ns/100ps
`default_nettype none

module ampc_host #(
  parameter int MUTE_DELAY = 40
) (
  input wire logic clk_sys,
  output logic reset_n,
  output logic mute_n,
  output logic mono_sel
);

  // Power applied with reset and mute low
  initial begin
    reset_n = 1'h0;
    mute_n = 1'h0;
    mono_sel = 1'h0;
  end

  // reset, mute held
  // Supplies are taken as stable once this returns
  task automatic hold_reset(input logic mono);
    @(posedge clk_sys);
    #1;
    reset_n = 1'h0;
    mute_n = 1'h0;
    mono_sel = mono;
  endtask

  task automatic release_reset();
    @(posedge clk_sys);
    #1;
    reset_n = 1'h1;
  endtask

  // Called just after an edge, so no extra wait here
  task automatic set_mono(input logic v);
    mono_sel = v;
  endtask

  // scaled unmute delay
  // One second shrinks to MUTE_DELAY cycles to keep the run short
  task automatic unmute();
    repeat (MUTE_DELAY) @(posedge clk_sys);
    #1;
    mute_n = 1'h1;
  endtask

  task automatic mute();
    @(posedge clk_sys);
    #1;
    mute_n = 1'h0;
  endtask

endmodule
`default_nettype wire

/* dv/tb_amp_reset_mute_mode_control.sv */
// Testbench for the reset, mute and mono sequencer
`timescale 1ns/100ps
`default_nettype none

module tb_amp_reset_mute_mode_control
  import ampc_pkg::*;
;
  localparam int INIT = 20;
  localparam int SOFT = 4;
  logic clk_sys;
  logic reset_n, mute_n, mono_sel;
  logic signed [15:0] audio_l, audio_r;
  ampc_fb_t fb_in;
  logic lp, ln, rp, rn;
  logic [1:0] bridge_oe_n;
  logic modulator_running, mono_active, soft_active;
  int err_total = 0;
  int checked = 0;
  int phase = 5;
  int cyc = 0;
  int last = -1;
  int n;
  logic prev_l = 1'h0;
  logic mono_exp = 1'h0;
  integer seed = 32'h6690A5A8;

  ampc_host #(.MUTE_DELAY(40)) host (.clk_sys(clk_sys), .reset_n(reset_n),
    .mute_n(mute_n), .mono_sel(mono_sel));

  ampc_ctrl #(.INIT_CYCLES(INIT), .SOFT_STEP_CYCLES(SOFT)) dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .mute_n(mute_n),
    .mono_sel(mono_sel), .audio_l(audio_l), .audio_r(audio_r),
    .fb_in(fb_in), .left_bridge_pos_out(lp), .left_bridge_neg_out(ln),
    .right_bridge_pos_out(rp), .right_bridge_neg_out(rn),
    .bridge_oe_n(bridge_oe_n), .modulator_running(modulator_running),
    .mono_active(mono_active), .soft_active(soft_active));

  initial begin
    clk_sys = 1'h0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (err_total == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Random samples and feedback, full scale included for order drop
  always @(posedge clk_sys) begin
    #1;
    audio_l = 16'($random(seed));
    audio_r = 16'($random(seed));
    fb_in = ampc_fb_t'(4'($random(seed)));
  end

  // Phase model checked at the falling edge, clear of input changes
  always @(negedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      final_report();
    end
    if (phase <= 2) begin
      chk(bridge_oe_n, 2'h3);
      chk({lp, ln, rp, rn}, 4'h0);
      if (phase == 0) chk(modulator_running, 1'h0);
      if (phase == 2) chk(modulator_running, 1'h1);
    end
    if (phase == 3 || phase == 4) begin
      chk(bridge_oe_n, 2'h0);
      chk(ln, !lp);
      if (mono_exp) chk({rp, rn}, {lp, ln});
      else chk(rn, !rp);
      if (lp !== prev_l) begin
        if (last >= 0) chk(cyc - last >= 8 && (cyc - last) % 2 == 0, 1'h1);
        last = cyc;
      end
    end
    prev_l = lp;
  end

  initial begin
    audio_l = 16'h0;
    audio_r = 16'h0;
    fb_in = '0;
    for (int m = 0; m < 2; m++) begin
      mono_exp = m[0];
      phase = 5;
      host.hold_reset(mono_exp);
      @(posedge clk_sys);
      #1;
      phase = 0;
      repeat (2) @(posedge clk_sys);
      host.release_reset();
      phase = 1;
      n = 0;
      while (modulator_running !== 1'h1 && n < 100) begin
        @(posedge clk_sys);
        #1;
        n++;
        // Later mono changes must not take effect
        if (n == 3) host.set_mono(~mono_exp);
      end
      chk(n >= INIT && n <= INIT + 2, 1'h1);
      phase = 2;
      chk(mono_active, mono_exp);
      host.unmute();
      phase = 5;
      @(posedge clk_sys);
      #1;
      chk(bridge_oe_n, 2'h0);
      chk(soft_active, 1'h1);
      last = -1;
      prev_l = lp;
      phase = 3;
      n = 1;
      while (soft_active === 1'h1 && n < 100) begin
        @(posedge clk_sys);
        #1;
        n++;
      end
      chk(n >= 8 * SOFT - 1 && n <= 8 * SOFT + 1, 1'h1);
      phase = 4;
      repeat (60) @(posedge clk_sys);
      chk(mono_active, mono_exp);
      host.mute();
      phase = 5;
      repeat (2) @(posedge clk_sys);
      #1;
      chk(bridge_oe_n, 2'h3);
      phase = 2;
      repeat (10) @(posedge clk_sys);
    end
    final_report();
  end

endmodule
`default_nettype wire
